// ===== verilog/csq_chip_select_map.vh
// constants for the chip-select qualification block: offsets, fields, resets, codes, timing
`ifndef CSQ_CHIP_SELECT_MAP_VH
`define CSQ_CHIP_SELECT_MAP_VH
// ====================================================================
// register offsets (byte addresses on the 16-bit register port)
`define CSQ_A_LATCH 8'h41
`define CSQ_A_STATUS 8'h42
`define CSQ_A_PINA0 8'h44
`define CSQ_A_PINA1 8'h46
`define CSQ_A_SEL_FIRST 8'h48
`define CSQ_A_SEL_LAST 8'h77
`define CSQ_SEL_SHIFT 2
`define CSQ_SEL_COUNT 12
// ====================================================================
// option register fields
`define CSQ_F_MODE 15
`define CSQ_F_BYTE 14:13
`define CSQ_F_RW 12:11
`define CSQ_F_STROBE_TIMING_BIT 10
`define CSQ_F_ACK 9:6
`define CSQ_F_SPACE 5:4
`define CSQ_F_IPL 3:1
`define CSQ_F_AUTOVECTOR_SIGNAL 0
// base register fields and the bus address lines compared with base and level
`define CSQ_F_BASE 15:3
`define CSQ_F_BLOCK_SIZE_CODE 2:0
`define CSQ_F_ADDR_HI 23:11
`define CSQ_F_ADDR_IPL 3:1
// ====================================================================
// reset values
`define CSQ_RST_BOOT_OPT 16'h7B70
`define CSQ_RST_BOOT_BASE 16'h0007
`define CSQ_RST_SEL 16'h0000
`define CSQ_RST_LATCH 7'h7F
`define CSQ_RST_PINA0 16'h0003
`define CSQ_RST_PINA1 8'h00
// ====================================================================
// field codes
`define CSQ_PA_DISCRETE 2'h0
`define CSQ_PA_ALT 2'h1
`define CSQ_PA_PORT8 2'h2
`define CSQ_PA_PORT16 2'h3
`define CSQ_LANE_LOWER 2'h1
`define CSQ_LANE_UPPER 2'h2
`define CSQ_LANE_BOTH 2'h3
`define CSQ_RW_READ 2'h1
`define CSQ_RW_WRITE 2'h2
`define CSQ_RW_BOTH 2'h3
`define CSQ_SP_CPU 2'h0
`define CSQ_SP_USER 2'h1
`define CSQ_SP_SUPER 2'h2
`define CSQ_SP_BOTH 2'h3
`define CSQ_ACK_FAST 4'hE
`define CSQ_ACK_EXT 4'hF
`define CSQ_IPL_ANY 3'h0
// ====================================================================
// timing in clock cycles counted from the first cycle of address strobe
`define CSQ_ACK_BASE_CNT 5'h02
`define CSQ_ACK_FAST_CNT 5'h01
`define CSQ_CNT_MAX 5'h1F
// discrete-output latch bit k drives select k plus this index
`define CSQ_LATCH_FIRST_SEL 4
`define CSQ_LATCH_LAST_SEL 10
`endif

// ===== verilog/csq_chip_select_option_logic.v
// chip-select qualification, option and base registers, discrete output latch
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/100ps
// ====================================================================
// Notes on behaviour
// R1 - select, internal ack or autovector only when address and every option agree
// R2 - address compare uses only base field bits 23 down to 11
// R3 - software keeps base a multiple of block size, else matching undefined
// R4 - block size code picks compared lines: 000 uses 23:11, 111 uses 23:20
// R5 - mode 0 times select from strobes, mode 1 locks it to slow clock
// R6 - synchronous mode ignores ack code and flags a pending slow-clock cycle
// R7 - on 16-bit pins byte field gates lanes: off, lower, upper, both
// R8 - direction field: 01 reads, 10 writes, 11 both; 00 reserved
// R9 - asynchronous strobe bit: 0 follows address strobe, 1 data strobe
// R10 - ack codes 0 to 13 give internal ack after that many wait states
// R11 - ack code 1110 ends the access internally in two cycles
// R12 - ack code 1111 leaves ack to the external device, none internally
// R13 - space field: cpu, user, supervisor, or supervisor and user
// R14 - cpu space compares address lines 3:1 of interrupt ack with level
// R15 - level 000 matches any level, 1 to 7 match exactly
// R16 - level field changes select response only, never interrupt recognition
// R17 - cpu space with autovector bit raises autovector on external ack
// R18 - autovector answers only requests from external request pins
// R19 - software never sets autovector bit on a synchronous select
// R20 - boot options reset to async, both bytes, rw, as, 13 waits, s/u
// R21 - discrete-output pins show the matching output latch bit
// R22 - latch bit 7 is fixed zero; others reset to one
// R23 - selects are active low and drop when the bus cycle ends
`include "csq_chip_select_map.vh"

module csq_chip_select_option_logic (
    input wire clk_in,
    input wire rst_n_in,
    input wire ce_in,
    input wire [7:0] reg_addr_in,
    input wire [15:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [15:0] reg_rdata_out,
    input wire [23:0] cyc_addr_in,
    input wire cyc_as_in,
    input wire cyc_ds_in,
    input wire cyc_read_in,
    input wire cyc_upper_in,
    input wire cyc_lower_in,
    input wire cyc_cpu_space_in,
    input wire cyc_super_in,
    input wire cyc_iack_in,
    input wire cyc_iack_ext_in,
    input wire slow_peripheral_clock_phase_in,
    output reg [11:0] select_n_out,
    output reg data_size_acknowledge_out,
    output reg autovector_signal_out,
    output reg slow_peripheral_clock_pending_out
);

    // ====================================================================
    // functions
    function [12:0] csq_blk_mask;
        input [2:0] code;
        begin
            case (code) // R4
                3'h0: csq_blk_mask = 13'h1FFF;
                3'h1: csq_blk_mask = 13'h1FFC;
                3'h2: csq_blk_mask = 13'h1FF8;
                3'h3: csq_blk_mask = 13'h1FE0;
                3'h4: csq_blk_mask = 13'h1FC0;
                3'h5: csq_blk_mask = 13'h1F80;
                3'h6: csq_blk_mask = 13'h1F00;
                default: csq_blk_mask = 13'h1E00;
            endcase
        end
    endfunction

    // only the upper lines take part; low bits of an unaligned base are dropped by the mask
    function csq_addr_match;
        input [15:0] base;
        input [23:0] addr;
        reg [12:0] mask;
        begin
            mask = csq_blk_mask(base[`CSQ_F_BLOCK_SIZE_CODE]);
            csq_addr_match = ((base[`CSQ_F_BASE] ^ addr[`CSQ_F_ADDR_HI]) & mask) == 13'h0000; // R2 R3
        end
    endfunction

    function csq_ack_due;
        input [3:0] code;
        input [4:0] cnt;
        begin
            if (code == `CSQ_ACK_FAST)
                csq_ack_due = cnt >= `CSQ_ACK_FAST_CNT; // R11
            else
                csq_ack_due = cnt >= ({1'b0, code} + `CSQ_ACK_BASE_CNT); // R10
        end
    endfunction

    // ====================================================================
    // registers
    reg [15:0] base_mem [0:11];
    reg [15:0] opt_mem [0:11];
    reg [15:0] pin_assign0;
    reg [7:0] pin_assign1;
    reg [6:0] out_latch;
    reg [4:0] cyc_cnt;
    reg [15:0] next_rdata;
    integer i;

    wire [23:0] pin_assign = {pin_assign1, pin_assign0};
    wire in_sel_win = (reg_addr_in >= `CSQ_A_SEL_FIRST) && (reg_addr_in <= `CSQ_A_SEL_LAST) && !reg_addr_in[0];
    wire [7:0] sel_off = reg_addr_in - `CSQ_A_SEL_FIRST;
    wire [3:0] sel_idx = sel_off[5:2];
    wire sel_is_opt = sel_off[1];

    // ====================================================================
    // register writes
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            for (i = 0; i < `CSQ_SEL_COUNT; i = i + 1) begin
                base_mem[i] <= `CSQ_RST_SEL;
                opt_mem[i] <= `CSQ_RST_SEL;
            end
            base_mem[0] <= `CSQ_RST_BOOT_BASE;
            opt_mem[0] <= `CSQ_RST_BOOT_OPT; // R20
            pin_assign0 <= `CSQ_RST_PINA0;
            pin_assign1 <= `CSQ_RST_PINA1;
            out_latch <= `CSQ_RST_LATCH; // R22
        end else if (ce_in && reg_wr_in) begin
            if (in_sel_win) begin
                if (sel_is_opt)
                    opt_mem[sel_idx] <= reg_wdata_in;
                else
                    base_mem[sel_idx] <= reg_wdata_in;
            end
            if (reg_addr_in == `CSQ_A_PINA0)
                pin_assign0 <= reg_wdata_in;
            if (reg_addr_in == `CSQ_A_PINA1)
                pin_assign1 <= reg_wdata_in[7:0];
            // bit 7 has no storage, so a write there is lost
            if (reg_addr_in == `CSQ_A_LATCH)
                out_latch <= reg_wdata_in[6:0]; // R22
        end
    end

    // ====================================================================
    // register reads, unmapped addresses read zero
    always @* begin
        next_rdata = 16'h0000;
        if (in_sel_win)
            next_rdata = sel_is_opt ? opt_mem[sel_idx] : base_mem[sel_idx];
        else if (reg_addr_in == `CSQ_A_LATCH)
            next_rdata = {9'h000, out_latch}; // R22
        else if (reg_addr_in == `CSQ_A_STATUS)
            next_rdata = {4'h0, ~select_n_out};
        else if (reg_addr_in == `CSQ_A_PINA0)
            next_rdata = pin_assign0;
        else if (reg_addr_in == `CSQ_A_PINA1)
            next_rdata = {8'h00, pin_assign1};
    end

    always @(posedge clk_in) begin
        if (!rst_n_in)
            reg_rdata_out <= 16'h0000;
        else if (ce_in)
            reg_rdata_out <= reg_rd_in ? next_rdata : 16'h0000;
    end

    // ====================================================================
    // bus cycle age, restarts whenever address strobe drops
    always @(posedge clk_in) begin
        if (!rst_n_in)
            cyc_cnt <= 5'h00;
        else if (ce_in) begin
            if (!cyc_as_in)
                cyc_cnt <= 5'h00;
            else if (cyc_cnt != `CSQ_CNT_MAX)
                cyc_cnt <= cyc_cnt + 5'h01;
        end
    end

    // ====================================================================
    // per-select qualification
    wire [11:0] hit;
    wire [11:0] pend;
    wire [11:0] ack_hit;
    wire [11:0] autovector_signal_hit;
    wire [11:0] next_pin;

    genvar g;
    generate
        for (g = 0; g < `CSQ_SEL_COUNT; g = g + 1) begin : sel
            wire [15:0] opt = opt_mem[g];
            wire [1:0] pa = pin_assign[2 * g + 1:2 * g];
            wire [1:0] rw = opt[`CSQ_F_RW];
            wire [1:0] lane = opt[`CSQ_F_BYTE];
            wire [1:0] space = opt[`CSQ_F_SPACE];
            wire [2:0] lvl = opt[`CSQ_F_IPL];
            wire amatch = csq_addr_match(base_mem[g], cyc_addr_in);
            wire rw_ok = (rw == `CSQ_RW_BOTH) || (rw == `CSQ_RW_READ && cyc_read_in) ||
                (rw == `CSQ_RW_WRITE && !cyc_read_in); // R8
            // lanes only gate pins wired as 16-bit ports
            wire byte_ok = (pa != `CSQ_PA_PORT16) || (lane == `CSQ_LANE_BOTH) ||
                (lane == `CSQ_LANE_LOWER && cyc_lower_in) || (lane == `CSQ_LANE_UPPER && cyc_upper_in); // R7
            // level compare feeds this select only and reaches no interrupt logic
            wire lvl_ok = (lvl == `CSQ_IPL_ANY) || (lvl == cyc_addr_in[`CSQ_F_ADDR_IPL]); // R15 R16
            wire space_ok = (space == `CSQ_SP_CPU) ? (cyc_cpu_space_in && cyc_iack_in && lvl_ok) : // R14
                (!cyc_cpu_space_in && ((space == `CSQ_SP_BOTH) ||
                (space == `CSQ_SP_SUPER && cyc_super_in) || (space == `CSQ_SP_USER && !cyc_super_in))); // R13
            wire core = amatch && rw_ok && byte_ok && space_ok && cyc_as_in; // R1
            wire timed = opt[`CSQ_F_MODE] ? slow_peripheral_clock_phase_in : (!opt[`CSQ_F_STROBE_TIMING_BIT] || cyc_ds_in); // R5 R9
            wire is_select = (pa == `CSQ_PA_PORT8) || (pa == `CSQ_PA_PORT16);
            assign hit[g] = core && timed;
            assign pend[g] = core && opt[`CSQ_F_MODE]; // R6
            // ack is computed even when the pin is discrete or alternate
            assign ack_hit[g] = hit[g] && !opt[`CSQ_F_MODE] && (opt[`CSQ_F_ACK] != `CSQ_ACK_EXT) &&
                csq_ack_due(opt[`CSQ_F_ACK], cyc_cnt); // R6 R10 R11 R12
            assign autovector_signal_hit[g] = core && (space == `CSQ_SP_CPU) && opt[`CSQ_F_AUTOVECTOR_SIGNAL] && cyc_iack_ext_in; // R17 R18
            if (g >= `CSQ_LATCH_FIRST_SEL && g <= `CSQ_LATCH_LAST_SEL) begin : latched
                assign next_pin[g] = (pa == `CSQ_PA_DISCRETE) ? out_latch[g - `CSQ_LATCH_FIRST_SEL] : // R21
                    !(hit[g] && is_select);
            end else begin : plain
                assign next_pin[g] = !(hit[g] && is_select); // R23
            end
        end
    endgenerate

    // ====================================================================
    // registered outputs, one cycle behind the bus signals that cause them
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            select_n_out <= 12'hFFF;
            data_size_acknowledge_out <= 1'b0;
            autovector_signal_out <= 1'b0;
            slow_peripheral_clock_pending_out <= 1'b0;
        end else if (ce_in) begin
            select_n_out <= next_pin; // R23
            data_size_acknowledge_out <= |ack_hit; // R12
            autovector_signal_out <= |autovector_signal_hit; // R17
            slow_peripheral_clock_pending_out <= |pend; // R6
        end
    end

endmodule // csq_chip_select_option_logic

// ===== dv/csq_chip_select_assertions.sv
// concurrent checks on the chip-select qualification ports
`timescale 1ns/100ps
// ==========
module csq_checker (
    input wire clk_in,
    input wire rst_n_in,
    input wire [7:0] reg_addr_in,
    input wire reg_rd_in,
    input wire [15:0] reg_rdata_out,
    input wire cyc_as_in,
    input wire cyc_cpu_space_in,
    input wire cyc_iack_ext_in,
    input wire [11:0] select_n_out,
    input wire data_size_acknowledge_out,
    input wire autovector_signal_out,
    input wire slow_peripheral_clock_pending_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // as low then high: first cycle of a bus cycle
    sequence cyc_start;
        !cyc_as_in ##1 cyc_as_in;
    endsequence
    sel_needs_as_a: assert property (!select_n_out[0] |-> $past(cyc_as_in))
        else $error("boot select without strobe");
    cyc_end_drop_a: assert property ($fell(cyc_as_in) |=> select_n_out[0] && !data_size_acknowledge_out
        && !autovector_signal_out && !slow_peripheral_clock_pending_out) else $error("outputs held after cycle end");
    ack_not_early_a: assert property (cyc_start |-> !data_size_acknowledge_out [*2])
        else $error("ack before two cycles");
    ack_needs_as_a: assert property (data_size_acknowledge_out |-> $past(cyc_as_in))
        else $error("ack without strobe");
    autovector_signal_cause_a: assert property (autovector_signal_out |-> $past(cyc_as_in)
        && $past(cyc_cpu_space_in) && $past(cyc_iack_ext_in)) else $error("autovector without cause");
    pend_no_ack_a: assert property (slow_peripheral_clock_pending_out |-> !data_size_acknowledge_out)
        else $error("ack in synchronous mode");
    pend_needs_as_a: assert property ($rose(slow_peripheral_clock_pending_out) |-> $past(cyc_as_in))
        else $error("pending without strobe");
    latch_top_zero_a: assert property (reg_rd_in && reg_addr_in == 8'h41 |=> reg_rdata_out[15:7] == 9'h000)
        else $error("latch bit 7 read nonzero");
    cover property (cyc_start ##1 !select_n_out[0]);
endmodule // csq_checker
bind csq_chip_select_option_logic csq_checker i_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .cyc_as_in(cyc_as_in),
    .cyc_cpu_space_in(cyc_cpu_space_in), .cyc_iack_ext_in(cyc_iack_ext_in), .select_n_out(select_n_out),
    .data_size_acknowledge_out(data_size_acknowledge_out), .autovector_signal_out(autovector_signal_out),
    .slow_peripheral_clock_pending_out(slow_peripheral_clock_pending_out));

// ===== dv/csq_ext_mem.sv
// external memory model behind the boot select
`timescale 1ns/100ps
// ==========
module csq_ext_mem (
    input wire clk_in,
    input wire select_n_in,
    output reg ext_ack_out,
    output integer hits_out
);
    reg [1:0] age;
    initial begin
        ext_ack_out = 1'b0;
        hits_out = 0;
        age = 2'h0;
    end
    // slow device: terminates with its own ack two cycles into the select
    always @(posedge clk_in) begin
        age <= select_n_in ? 2'h0 : (age == 2'h3 ? age : age + 2'h1);
        ext_ack_out <= !select_n_in && age == 2'h1;
        if (!select_n_in && age == 2'h0) hits_out <= hits_out + 1;
    end
endmodule // csq_ext_mem

// ===== dv/testbench.sv
// self-checking bench for the chip-select qualification block
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; $display("FAIL %0t got %0h exp %0h", $time, a, b); end end
// ==========
module testbench;
    localparam [15:0] B = 16'h0007;
    localparam [8:0] S = 9'h1D3;
    reg clk_in = 1'b0;
    reg rst_n_in = 1'b0;
    reg ce_in = 1'b1;
    reg [7:0] reg_addr_in = 8'h00;
    reg [15:0] reg_wdata_in = 16'h0000;
    reg reg_wr_in = 1'b0;
    reg reg_rd_in = 1'b0;
    reg [23:0] cyc_addr_in = 24'h000000;
    reg [8:0] ctl = 9'h000;
    reg cyc_as_in = 1'b0;
    wire [15:0] reg_rdata_out;
    wire [11:0] select_n_out;
    wire ack, autovector_signal, pend, ext_ack;
    integer error_cnt = 0, comparisons = 0, tick = 0, hits, h;
    // ctl: read, upper, lower, cpu, super, iack, ext, ds, slow clock phase
    csq_chip_select_option_logic i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .cyc_addr_in(cyc_addr_in), .cyc_as_in(cyc_as_in),
        .cyc_ds_in(ctl[1] & cyc_as_in), .cyc_read_in(ctl[8]), .cyc_upper_in(ctl[7]), .cyc_lower_in(ctl[6]),
        .cyc_cpu_space_in(ctl[5]), .cyc_super_in(ctl[4]), .cyc_iack_in(ctl[3]), .cyc_iack_ext_in(ctl[2]),
        .slow_peripheral_clock_phase_in(ctl[0]), .select_n_out(select_n_out), .data_size_acknowledge_out(ack),
        .autovector_signal_out(autovector_signal), .slow_peripheral_clock_pending_out(pend));
    csq_ext_mem i_mem (.clk_in(clk_in), .select_n_in(select_n_out[0]), .ext_ack_out(ext_ack), .hits_out(hits));
    always #50 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        tick++;
        if (tick == 5000) begin
            error_cnt++;
            finish_test;
        end
    end
    task finish_test;
        $display("compares %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task wr(input [7:0] a, input [15:0] d);
        @(posedge clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task rd(input [7:0] a, input [15:0] e);
        @(posedge clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1 `CHK(reg_rdata_out, e)
    endtask
    // one boot-select bus cycle; x = {select, autovector, pending}, e = earliest ack cycle, 0 none
    task t(input [15:0] o, input [15:0] b, input [23:0] a, input [8:0] c, input [2:0] x, input [4:0] e);
        reg [2:0] seen;
        integer at, i;
        seen = 3'h0;
        at = 0;
        wr(8'h48, b);
        wr(8'h4A, o);
        @(posedge clk_in);
        cyc_addr_in <= a;
        ctl <= c;
        cyc_as_in <= 1'b1;
        for (i = 1; i < 19; i++) begin
            @(posedge clk_in);
            #1 seen = seen | {!select_n_out[0], autovector_signal, pend};
            if (ack === 1'b1 && at == 0) at = i;
        end
        cyc_as_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        `CHK(seen, x)
        `CHK(e == 0 ? at == 0 : at >= e && at <= e + 1, 1'b1)
        $display("cycle test %0h %0h done", o, a);
    endtask
    initial begin
        repeat (8) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(8'h4A, 16'h7B70);
        rd(8'h48, 16'h0007);
        rd(8'h41, 16'h007F);
        rd(8'h40, 16'h0000);
        wr(8'h41, 16'h00AA);
        rd(8'h41, 16'h002A);
        wr(8'h41, 16'h0000);
        @(posedge clk_in);
        #1 `CHK($countones(~select_n_out), 7)
        rd(8'h42, 16'h07F0);
        wr(8'h41, 16'h007F);
        @(posedge clk_in);
        #1 `CHK(select_n_out, 12'hFFF)
        // clock enable low: a write must leave the latch untouched
        ce_in <= 1'b0;
        wr(8'h41, 16'h0000);
        @(posedge clk_in);
        ce_in <= 1'b1;
        rd(8'h41, 16'h007F);
        $display("register test done");
        t(16'h7B70, B, 24'h000100, S, 3'h4, 15);
        t(16'h7830, B, 24'h000100, S, 3'h4, 2);
        t(16'h7BB0, B, 24'h000100, S, 3'h4, 1);
        h = hits;
        t(16'h7BF0, B, 24'h000100, S, 3'h4, 0);
        `CHK(hits - h, 1)
        t(16'h7830, 16'h0008, 24'h000800, S, 3'h4, 2);
        t(16'h7830, 16'h0008, 24'h001000, S, 3'h0, 0);
        t(16'h7830, 16'h1007, 24'h1FFFFE, S, 3'h4, 2);
        t(16'h6830, B, 24'h000100, 9'h0D3, 3'h0, 0);
        t(16'h7030, B, 24'h000100, 9'h0D3, 3'h4, 2);
        t(16'h7C30, B, 24'h000100, 9'h1D1, 3'h0, 0);
        t(16'h3830, B, 24'h000100, 9'h193, 3'h0, 0);
        t(16'h5830, B, 24'h000100, 9'h193, 3'h4, 2);
        t(16'h7810, B, 24'h000100, S, 3'h0, 0);
        t(16'h7810, B, 24'h000100, 9'h1C3, 3'h4, 2);
        t(16'h7820, B, 24'h000100, 9'h1C3, 3'h0, 0);
        t(16'h7BC7, B, 24'h000006, 9'h1EF, 3'h6, 0);
        t(16'h7BC7, B, 24'h00000A, 9'h1EF, 3'h0, 0);
        t(16'h7BC7, B, 24'h000006, 9'h1EB, 3'h4, 0);
        t(16'h7BC0, B, 24'h00000E, 9'h1EF, 3'h4, 0);
        t(16'hF830, B, 24'h000100, S, 3'h5, 0);
        t(16'hF830, B, 24'h000100, 9'h1D2, 3'h1, 0);
        // reset again in mid-run: boot options and latch return to defaults
        wr(8'h41, 16'h0000);
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(8'h4A, 16'h7B70);
        rd(8'h41, 16'h007F);
        $display("mid-run reset test done");
        finish_test;
    end
endmodule // testbench
